// file: adm_card_model.sv
// Behavioural model of the onboard memories and backplane cards behind the decoder
module adm_card_model (
   // Onboard chip enables
   input  wire logic [3:0] rom_n_in,
   input  wire logic [3:0] kb_n_in,
   // Backplane side
   input  wire logic [1:0] ext_n_in,
   input  wire logic       memrq_n_in,
   input  wire logic       iorq_n_in,
   // Who answers the cycle
   output logic [3:0]      who_out,
   output logic            clash_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] onboard_cnt;
   always_comb begin
      onboard_cnt = 4'h0;
      who_out = 4'h0;
      for (int i = 3; i >= 0; i--) begin
         onboard_cnt = onboard_cnt + {3'h0, !rom_n_in[i]} + {3'h0, !kb_n_in[i]};
         if (!kb_n_in[i]) who_out = 4'(5 + i);
         if (!rom_n_in[i]) who_out = 4'(1 + i);
      end
      if (onboard_cnt == 4'h0 && !memrq_n_in) who_out = 4'h9;
      if (onboard_cnt == 4'h0 && !iorq_n_in) who_out = 4'ha;
      // Two drivers on the data bus, or an onboard part without a memory cycle
      clash_out = (onboard_cnt > 4'h1) || (onboard_cnt != 4'h0 && (ext_n_in != 2'b11 || memrq_n_in)) ||
                  (!memrq_n_in && !iorq_n_in);
   end
endmodule

// file: adm_decoder.sv
// Top of the processor-card address decoder: table lookup, RAM split, registered selects
`include "adm_map.svh"
module adm_decoder (
   // Clock and reset
   input  wire logic               core_clk_in,
   input  wire logic               reset_n_in,
   // Processor address and strap
   input  wire adm_pkg::adm_addr_t addr_in,
   input  wire logic               map_option_strap_in,
   input  wire logic               dma_grant_n_in,
   // Table replacement
   input  wire logic               table_wr_en_in,
   input  wire adm_pkg::adm_idx_t  table_wr_idx_in,
   input  wire adm_pkg::adm_word_t table_wr_word_in,
   // Onboard ROM enables
   output logic                    rom_bank0_enable_n_out,
   output logic                    rom_bank1_enable_n_out,
   output logic                    rom_bank2_enable_n_out,
   output logic                    rom_bank3_enable_n_out,
   // Onboard RAM selects
   output logic                    ram_lower_half_sel_n_out,
   output logic                    ram_upper_half_sel_n_out,
   output logic                    ram_kb1_enable_n_out,
   output logic                    ram_kb2_enable_n_out,
   output logic                    ram_kb3_enable_n_out,
   output logic                    ram_kb4_enable_n_out,
   // Backplane
   output logic                    ext_mem_buf_enable_a_n_out,
   output logic                    ext_mem_buf_enable_b_n_out,
   output logic                    memrq_n_out,
   output logic                    iorq_n_out,
   output logic [7:0]              io_port_out
);
   adm_pkg::adm_idx_t  idx;
   adm_pkg::adm_word_t word;

   // First stage beside the table read
   logic               a10_r;
   logic               a10_nxt;
   logic               dma_r;
   logic               dma_nxt;
   logic [7:0]         port_r;
   logic [7:0]         port_nxt;

   // Gated word and split outputs
   adm_pkg::adm_word_t gword;
   logic               kb1_n;
   logic               kb2_n;
   logic               kb3_n;
   logic               kb4_n;
   logic               ext_a_n;
   logic               ext_b_n;

   // Output stage
   adm_pkg::adm_word_t out_word_r;
   adm_pkg::adm_word_t out_word_nxt;
   logic [3:0]         kb_n_r;
   logic [3:0]         kb_n_nxt;
   logic [1:0]         ext_n_r;
   logic [1:0]         ext_n_nxt;
   logic [7:0]         io_port_r;
   logic [7:0]         io_port_nxt;

   assign idx = {map_option_strap_in, addr_in[15:8]};

   adm_table u_table (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .rd_idx_in   (idx),
      .rd_word_out (word),
      .wr_en_in    (table_wr_en_in),
      .wr_idx_in   (table_wr_idx_in),
      .wr_word_in  (table_wr_word_in)
   );

   always_comb begin
      a10_nxt  = addr_in[`ADM_A10_BIT];
      dma_nxt  = !dma_grant_n_in;
      port_nxt = addr_in[7:0];
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         a10_r  <= 1'b0;
         dma_r  <= 1'b0;
         port_r <= 8'h00;
      end else begin
         a10_r  <= a10_nxt;
         dma_r  <= dma_nxt;
         port_r <= port_nxt;
      end
   end

   // Card is off the bus during DMA: every select and request idles
   always_comb begin
      gword = dma_r ? `ADM_W_IDLE : word;
   end

   adm_ram_dec u_ram_dec (
      .lower_sel_n_in (gword[`ADM_BIT_LOWER]),
      .upper_sel_n_in (gword[`ADM_BIT_UPPER]),
      .a10_in         (a10_r),
      .kb1_n_out      (kb1_n),
      .kb2_n_out      (kb2_n),
      .kb3_n_out      (kb3_n),
      .kb4_n_out      (kb4_n),
      .ext_a_n_out    (ext_a_n),
      .ext_b_n_out    (ext_b_n)
   );

   always_comb begin
      out_word_nxt = gword;
      kb_n_nxt     = {kb4_n, kb3_n, kb2_n, kb1_n};
      ext_n_nxt    = {ext_b_n, ext_a_n};
      if (dma_r)
         ext_n_nxt = 2'h3;
      io_port_nxt  = port_r;
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         out_word_r <= `ADM_W_IDLE;
         kb_n_r     <= 4'hf;
         ext_n_r    <= 2'h3;
         io_port_r  <= 8'h00;
      end else begin
         out_word_r <= out_word_nxt;
         kb_n_r     <= kb_n_nxt;
         ext_n_r    <= ext_n_nxt;
         io_port_r  <= io_port_nxt;
      end
   end

   assign rom_bank0_enable_n_out     = out_word_r[`ADM_BIT_ROM0];
   assign rom_bank1_enable_n_out     = out_word_r[`ADM_BIT_ROM0+1];
   assign rom_bank2_enable_n_out     = out_word_r[`ADM_BIT_ROM0+2];
   assign rom_bank3_enable_n_out     = out_word_r[`ADM_BIT_ROM3];
   assign ram_lower_half_sel_n_out   = out_word_r[`ADM_BIT_LOWER];
   assign ram_upper_half_sel_n_out   = out_word_r[`ADM_BIT_UPPER];
   assign ram_kb1_enable_n_out       = kb_n_r[0];
   assign ram_kb2_enable_n_out       = kb_n_r[1];
   assign ram_kb3_enable_n_out       = kb_n_r[2];
   assign ram_kb4_enable_n_out       = kb_n_r[3];
   assign ext_mem_buf_enable_a_n_out = ext_n_r[0];
   assign ext_mem_buf_enable_b_n_out = ext_n_r[1];
   assign memrq_n_out                = out_word_r[`ADM_BIT_MEM];
   assign iorq_n_out                 = out_word_r[`ADM_BIT_IO];
   assign io_port_out                = io_port_r;

   // Checks; no table writes in flight, no DMA for the map checks
   logic quiet;
   logic [2:0] settle_r;
   logic [2:0] settle_nxt;

   always_comb begin
      settle_nxt = (table_wr_en_in || !dma_grant_n_in) ? 3'h0 :
                   (settle_r == 3'h7) ? settle_r : settle_r + 3'h1;
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         settle_r <= 3'h0;
      else
         settle_r <= settle_nxt;
   end

   assign quiet = (settle_r == 3'h7);

   property p_rom_map;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (quiet && addr_in[15:13] == 3'h7 && !table_wr_en_in && dma_grant_n_in)
      |-> ##2 (memrq_n_out == 1'b0 && iorq_n_out == 1'b1 &&
               ram_lower_half_sel_n_out == 1'b0 && ram_upper_half_sel_n_out == 1'b0 &&
               {rom_bank3_enable_n_out, rom_bank2_enable_n_out,
                rom_bank1_enable_n_out, rom_bank0_enable_n_out} ==
               ~(4'h1 << (2'h3 - $past(addr_in[12:11], 2))) &&
               {ram_kb4_enable_n_out, ram_kb3_enable_n_out,
                ram_kb2_enable_n_out, ram_kb1_enable_n_out} == 4'hf);
   endproperty
   a_rom_map: assert property (p_rom_map) else $error("ROM page decoded wrongly");

   property p_fffe;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (quiet && addr_in == 16'hfffe && !map_option_strap_in && dma_grant_n_in)
      |-> ##2 (rom_bank0_enable_n_out == 1'b0 && memrq_n_out == 1'b0);
   endproperty
   a_fffe: assert property (p_fffe) else $error("FFFE does not select ROM 0");

   property p_default_ram;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (quiet && addr_in[15:12] == 4'hd && !map_option_strap_in && dma_grant_n_in)
      |-> ##2 (memrq_n_out == 1'b0 &&
               {ram_kb4_enable_n_out, ram_kb3_enable_n_out,
                ram_kb2_enable_n_out, ram_kb1_enable_n_out} ==
               ~(4'h1 << $past(addr_in[11:10], 2)));
   endproperty
   a_default_ram: assert property (p_default_ram) else $error("Default RAM bank wrong");

   property p_default_io;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (quiet && addr_in[15:8] == 8'h00 && !map_option_strap_in && dma_grant_n_in)
      |-> ##2 (iorq_n_out == 1'b0 && memrq_n_out == 1'b1 && io_port_out == $past(addr_in[7:0], 2));
   endproperty
   a_default_io: assert property (p_default_io) else $error("Default I/O page wrong");

   property p_default_ext;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (quiet && addr_in[15:8] != 8'h00 && addr_in[15:12] < 4'hd &&
       !map_option_strap_in && dma_grant_n_in)
      |-> ##2 (memrq_n_out == 1'b0 && ext_mem_buf_enable_a_n_out == 1'b0 &&
               ext_mem_buf_enable_b_n_out == 1'b0 && ram_kb1_enable_n_out == 1'b1);
   endproperty
   a_default_ext: assert property (p_default_ext) else $error("External memory wrong");

   property p_option_map;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (quiet && map_option_strap_in && dma_grant_n_in && addr_in[15:13] != 3'h7)
      |-> ##2 ((iorq_n_out == 1'b0) == ($past(addr_in[15:8], 2) == 8'h80) &&
               (ram_kb1_enable_n_out == 1'b0) == ($past(addr_in[15:10], 2) == 6'h00) &&
               (ext_mem_buf_enable_a_n_out == 1'b0) == ($past(addr_in[15:12], 2) != 4'h0));
   endproperty
   a_option_map: assert property (p_option_map) else $error("Option map wrong");

   property p_dma_quiet;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (!dma_grant_n_in) |-> ##2 (rom_bank0_enable_n_out && rom_bank1_enable_n_out &&
         rom_bank2_enable_n_out && rom_bank3_enable_n_out && ram_kb1_enable_n_out &&
         ram_kb2_enable_n_out && ram_kb3_enable_n_out && ram_kb4_enable_n_out);
   endproperty
   a_dma_quiet: assert property (p_dma_quiet) else $error("Onboard memory active in DMA");

   property p_split;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      1'b1 |-> ((ram_kb1_enable_n_out & ram_kb2_enable_n_out) ||
                !ram_lower_half_sel_n_out || dma_r) &&
               (ext_mem_buf_enable_a_n_out ==
                !(ram_lower_half_sel_n_out & ram_upper_half_sel_n_out) ||
                $past(dma_r) || !$past(reset_n_in));
   endproperty
   a_split: assert property (p_split) else $error("RAM split inconsistent");

   property p_replace;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (table_wr_en_in && table_wr_idx_in == 9'h000) ##1
      (dma_grant_n_in && !table_wr_en_in && idx == 9'h000)
      |-> ##2 (memrq_n_out == $past(table_wr_word_in[7], 3) &&
               rom_bank0_enable_n_out == $past(table_wr_word_in[0], 3));
   endproperty
   a_replace: assert property (p_replace) else $error("Replaced entry not used");

   c_rom0: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      !rom_bank0_enable_n_out);
   c_io: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      !iorq_n_out && map_option_strap_in);
   c_kb4: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      !ram_kb4_enable_n_out);
   c_ext: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      !ext_mem_buf_enable_a_n_out ##1 !dma_grant_n_in);
endmodule

// file: adm_decoder_tb.sv
// Self-checking testbench of the address decoder with the card-side model
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module adm_decoder_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic               core_clk_in;
   logic               reset_n_in;
   adm_pkg::adm_addr_t addr;
   logic               strap;
   logic               dma_n;
   logic               wr_en;
   adm_pkg::adm_idx_t  wr_idx;
   adm_pkg::adm_word_t wr_word;
   logic [3:0]         rom_n;
   logic [3:0]         kb_n;
   logic               lo_n;
   logic               up_n;
   logic [1:0]         ext_n;
   logic               memrq_n;
   logic               iorq_n;
   logic [7:0]         io_port;
   logic [3:0]         who;
   logic               clash;
   logic [13:0]        all_n;
   int                 mismatches = 0;
   int                 cmp_count = 0;
   assign all_n = {rom_n, kb_n, lo_n, up_n, ext_n, memrq_n, iorq_n};

   adm_decoder adm_decoder_inst (
      .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .addr_in(addr),
      .map_option_strap_in(strap), .dma_grant_n_in(dma_n), .table_wr_en_in(wr_en),
      .table_wr_idx_in(wr_idx), .table_wr_word_in(wr_word),
      .rom_bank0_enable_n_out(rom_n[0]), .rom_bank1_enable_n_out(rom_n[1]),
      .rom_bank2_enable_n_out(rom_n[2]), .rom_bank3_enable_n_out(rom_n[3]),
      .ram_lower_half_sel_n_out(lo_n), .ram_upper_half_sel_n_out(up_n),
      .ram_kb1_enable_n_out(kb_n[0]), .ram_kb2_enable_n_out(kb_n[1]),
      .ram_kb3_enable_n_out(kb_n[2]), .ram_kb4_enable_n_out(kb_n[3]),
      .ext_mem_buf_enable_a_n_out(ext_n[0]), .ext_mem_buf_enable_b_n_out(ext_n[1]),
      .memrq_n_out(memrq_n), .iorq_n_out(iorq_n), .io_port_out(io_port));

   adm_card_model adm_card_model_inst (
      .rom_n_in(rom_n), .kb_n_in(kb_n), .ext_n_in(ext_n), .memrq_n_in(memrq_n),
      .iorq_n_in(iorq_n), .who_out(who), .clash_out(clash));

   initial begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end

   // Shipped map, worked out per strap setting and page
   function automatic adm_pkg::adm_word_t exp_word(input logic s, input adm_pkg::adm_page_t pg);
      case (pg[7:3])
         5'h1c: return 8'h47;
         5'h1d: return 8'h4b;
         5'h1e: return 8'h4d;
         5'h1f: return 8'h4e;
         default: ;
      endcase
      if (!s && pg == 8'h00) return 8'hbf;
      if (!s && pg[7:3] == 5'h1a) return 8'h6f;
      if (!s && pg[7:3] == 5'h1b) return 8'h5f;
      if (s && pg[7:3] == 5'h00) return 8'h6f;
      if (s && pg[7:3] == 5'h01) return 8'h5f;
      if (s && pg == 8'h80) return 8'hbf;
      return 8'h7f;
   endfunction

   task automatic check_now(input adm_pkg::adm_addr_t a, input logic s);
      adm_pkg::adm_word_t w;
      logic [3:0]         kb;
      w = exp_word(s, a[15:8]);
      kb = 4'hf;
      if (w[5:4] == 2'b10) kb = a[10] ? 4'b1101 : 4'b1110;
      else if (w[5:4] == 2'b01) kb = a[10] ? 4'b0111 : 4'b1011;
      `CHK("decode word", w, {memrq_n, iorq_n, up_n, lo_n, rom_n})
      `CHK("ram enables", kb, kb_n)
      `CHK("ext buffers", (w[5:4] == 2'b11) ? 2'b00 : 2'b11, ext_n)
      `CHK("io port", a[7:0], io_port)
      `CHK("bus clash", 1'b0, clash)
   endtask

   task automatic decode(input adm_pkg::adm_addr_t a, input logic s);
      @(posedge core_clk_in);
      #5 addr = a;
      strap = s;
      repeat (3) @(posedge core_clk_in);
      #1 check_now(a, s);
   endtask

   task automatic do_reset();
      @(posedge core_clk_in);
      #5 reset_n_in = 1'b0;
      repeat (3) @(posedge core_clk_in);
      #1 `CHK("reset idle", 14'h3fff, all_n)
      #4 reset_n_in = 1'b1;
      $display("test reset done");
   endtask

   task automatic t_default_map();
      adm_pkg::adm_addr_t l[15] = '{16'h0000, 16'h00ff, 16'h0100, 16'hcfff, 16'hd000, 16'hd3ff,
         16'hd400, 16'hd800, 16'hdc00, 16'hdfff, 16'he000, 16'he800, 16'hf000, 16'hf800, 16'hfffe};
      foreach (l[i]) decode(l[i], 1'b0);
      $display("test default map done");
   endtask

   task automatic t_option_map();
      adm_pkg::adm_addr_t l[14] = '{16'h0000, 16'h03ff, 16'h0400, 16'h0800, 16'h0c00, 16'h0fff,
         16'h1000, 16'h7fff, 16'h8000, 16'h80ff, 16'h8100, 16'hdfff, 16'he7ff, 16'hffff};
      foreach (l[i]) decode(l[i], 1'b1);
      $display("test option map done");
   endtask

   task automatic t_back_to_back();
      adm_pkg::adm_addr_t l[10] = '{16'hd000, 16'hd400, 16'hd800, 16'hdc00, 16'h0042,
         16'hf800, 16'he000, 16'h1234, 16'hd7ff, 16'h00a5};
      // Decode of the address set after edge i-2 stands after edge i
      for (int i = 0; i < 12; i++) begin
         @(posedge core_clk_in);
         #5 if (i < 10) addr = l[i];
         strap = 1'b0;
         if (i >= 2) #1 check_now(l[i-2], 1'b0);
      end
      $display("test back to back done");
   endtask

   task automatic t_dma();
      @(posedge core_clk_in);
      #5 addr = 16'hf800;
      dma_n = 1'b0;
      repeat (3) @(posedge core_clk_in);
      #1 `CHK("dma idle", 14'h3fff, all_n)
      `CHK("dma responder", 4'h0, who)
      #4 dma_n = 1'b1;
      decode(16'hf800, 1'b0);
      `CHK("rom0 responder", 4'h1, who)
      $display("test dma done");
   endtask

   task automatic t_table_write();
      @(posedge core_clk_in);
      #5 wr_en = 1'b1;
      wr_idx = 9'h000;
      wr_word = 8'h7f;
      @(posedge core_clk_in);
      #5 wr_en = 1'b0;
      addr = 16'h0012;
      strap = 1'b0;
      repeat (3) @(posedge core_clk_in);
      #1 `CHK("rewritten entry", 8'h7f, {memrq_n, iorq_n, up_n, lo_n, rom_n})
      `CHK("ext mem buffers", 2'b00, ext_n)
      `CHK("ext mem responder", 4'h9, who)
      do_reset();
      decode(16'h0012, 1'b0);
      `CHK("io responder", 4'ha, who)
      $display("test table write done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // About 150 cycles of tests; the limit leaves wide margin
   initial begin
      #250000;
      mismatches++;
      end_of_test();
   end

   initial begin
      reset_n_in = 1'b0;
      addr = 16'h0000;
      strap = 1'b0;
      dma_n = 1'b1;
      wr_en = 1'b0;
      wr_idx = 9'h000;
      wr_word = 8'hff;
      do_reset();
      t_default_map();
      t_option_map();
      t_back_to_back();
      t_dma();
      t_table_write();
      end_of_test();
   end
endmodule

// file: adm_map.svh
// Offsets, decode-word layout, default entries and page numbers of the address decoder
`ifndef ADM_MAP_SVH
`define ADM_MAP_SVH

`define ADM_IDX_W       9
`define ADM_DEPTH       512
`define ADM_WORD_W      8

`define ADM_BIT_MEM     7
`define ADM_BIT_IO      6
`define ADM_BIT_UPPER   5
`define ADM_BIT_LOWER   4
`define ADM_BIT_ROM3    3
`define ADM_BIT_ROM0    0

`define ADM_W_EXT_MEM   8'h7f
`define ADM_W_EXT_IO    8'hbf
`define ADM_W_ROM0      8'h4e
`define ADM_W_ROM1      8'h4d
`define ADM_W_ROM2      8'h4b
`define ADM_W_ROM3      8'h47
`define ADM_W_RAM_LO    8'h6f
`define ADM_W_RAM_HI    8'h5f
`define ADM_W_IDLE      8'hff

`define ADM_A10_BIT     10
`define ADM_PAGE_IO_DEF 8'h00
`define ADM_PAGE_IO_OPT 8'h80
`define ADM_PAGE_RAM_DEF 4'hd
`define ADM_PAGE_RAM_OPT 4'h0
`define ADM_PAGE_ROM    3'h7

`endif

// file: adm_pkg.sv
// Types shared by the address decoder files
package adm_pkg;
   typedef logic [7:0]  adm_word_t;
   typedef logic [8:0]  adm_idx_t;
   typedef logic [15:0] adm_addr_t;
   typedef logic [7:0]  adm_page_t;
endpackage

// file: adm_ram_dec.sv
// Splits the two RAM-half selects into four 1K enables or the external buffer enables
module adm_ram_dec (
   // Half selects and bank bit
   input  wire logic lower_sel_n_in,
   input  wire logic upper_sel_n_in,
   input  wire logic a10_in,
   // Chip enables
   output logic      kb1_n_out,
   output logic      kb2_n_out,
   output logic      kb3_n_out,
   output logic      kb4_n_out,
   // Backplane data input buffers
   output logic      ext_a_n_out,
   output logic      ext_b_n_out
);
   logic lower_only;
   logic upper_only;

   // Both halves low is a ROM cycle: RAM must stay off the data bus
   always_comb begin
      lower_only  = !lower_sel_n_in && upper_sel_n_in;
      upper_only  = !upper_sel_n_in && lower_sel_n_in;
      kb1_n_out   = !(lower_only && !a10_in);
      kb2_n_out   = !(lower_only && a10_in);
      kb3_n_out   = !(upper_only && !a10_in);
      kb4_n_out   = !(upper_only && a10_in);
      ext_a_n_out = !(lower_sel_n_in & upper_sel_n_in);
      ext_b_n_out = !(lower_sel_n_in & upper_sel_n_in);
   end
endmodule

// file: adm_table.sv
// Replaceable 512 x 8 decode table with registered read data
`include "adm_map.svh"
module adm_table (
   // Clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              reset_n_in,
   // Lookup
   input  wire adm_pkg::adm_idx_t rd_idx_in,
   output adm_pkg::adm_word_t     rd_word_out,
   // Replacement writes
   input  wire logic              wr_en_in,
   input  wire adm_pkg::adm_idx_t wr_idx_in,
   input  wire adm_pkg::adm_word_t wr_word_in
);
   adm_pkg::adm_word_t   mem_r [`ADM_DEPTH];
   logic [`ADM_DEPTH-1:0] over_r;
   logic [`ADM_DEPTH-1:0] over_nxt;
   adm_pkg::adm_word_t   rd_word_r;
   adm_pkg::adm_word_t   rd_word_nxt;

   // Shipped map; index bit 8 is the strap, bits 7:0 the page
   function automatic adm_pkg::adm_word_t default_word(input adm_pkg::adm_idx_t idx);
      adm_pkg::adm_page_t pg;
      pg = idx[7:0];
      if (pg[7:5] == `ADM_PAGE_ROM) begin
         unique case (pg[4:3])
            2'h0: default_word = `ADM_W_ROM3;
            2'h1: default_word = `ADM_W_ROM2;
            2'h2: default_word = `ADM_W_ROM1;
            2'h3: default_word = `ADM_W_ROM0;
         endcase
      end else if (!idx[8]) begin
         if (pg == `ADM_PAGE_IO_DEF)
            default_word = `ADM_W_EXT_IO;
         else if (pg[7:4] == `ADM_PAGE_RAM_DEF)
            default_word = pg[3] ? `ADM_W_RAM_HI : `ADM_W_RAM_LO;
         else
            default_word = `ADM_W_EXT_MEM;
      end else begin
         if (pg[7:4] == `ADM_PAGE_RAM_OPT)
            default_word = pg[3] ? `ADM_W_RAM_HI : `ADM_W_RAM_LO;
         else if (pg == `ADM_PAGE_IO_OPT)
            default_word = `ADM_W_EXT_IO;
         else
            default_word = `ADM_W_EXT_MEM;
      end
   endfunction

   always_comb begin
      over_nxt = over_r;
      if (wr_en_in)
         over_nxt[wr_idx_in] = 1'b1;
      rd_word_nxt = over_r[rd_idx_in] ? mem_r[rd_idx_in] : default_word(rd_idx_in);
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         over_r    <= '0;
         rd_word_r <= `ADM_W_IDLE;
      end else begin
         over_r    <= over_nxt;
         rd_word_r <= rd_word_nxt;
      end
   end

   // Storage itself needs no reset; the override bits gate it
   always_ff @(posedge core_clk_in) begin
      if (wr_en_in)
         mem_r[wr_idx_in] <= wr_word_in;
   end

   assign rd_word_out = rd_word_r;
endmodule
